// [hdl/dmm_ctl_pkg.sv]
// constants, register map and state encoding of the multimeter converter control
package dmm_ctl_pkg;
    // clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TONE_HIGH_HZ = 4096;
    localparam int TONE_LOW_HZ = 2048;
    localparam int CONV_CYCLES = 1638;
    localparam int INTEG_MAINS50 = 655;
    localparam int INTEG_MAINS60 = 545;
    localparam int INTEG_SHRINK = 5;
    localparam int LOAD_DELAY = 21;
    localparam int CNT_W = 11;
    // bus and register layout
    localparam int ADDR_W = 3;
    localparam int DATA_W = 4;
    localparam int DIGITS = 5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_CTL_RUN = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTL_FILT = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTL_RANGE = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CTL_INPUT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CTL_GAIN = 3'h4;
    // control register 0
    localparam int BIT_HOLD = 3;
    localparam int BIT_TONE = 2;
    localparam int BIT_BEEP = 1;
    localparam int BIT_STANDBY = 0;
    // control register 1
    localparam int BIT_RANGE0 = 3;
    localparam int BIT_FILT_SHORT = 2;
    localparam int BIT_DIV5 = 1;
    localparam int BIT_MAINS = 0;
    // control register 3
    localparam int BIT_DC = 3;
    localparam int BIT_EXTERNAL_AC_BIT = 2;
    localparam int BIT_DIV_SENSE = 1;
    localparam int BIT_OHMS = 0;
    // control register 4
    localparam int BIT_CURRENT = 3;
    localparam int BIT_DOUBLE = 2;
    localparam int BIT_ZERO = 1;
    localparam int BIT_FILT_ON = 0;
    // status register
    localparam int ST_ALWAYS1 = 3;
    localparam int ST_CONT = 2;
    localparam int ST_RUNNING = 1;
    localparam int ST_LOWBAT = 0;
    // result coding
    localparam int RES_W = 17;
    localparam logic [RES_W-1:0] RESULT_MODULUS = 17'h186A0;
    localparam logic [DATA_W-1:0] CTL_GAIN_RESET = 4'h1;
    localparam logic [DATA_W-1:0] CTL_OTHER_RESET = 4'h0;

    typedef enum logic [1:0] {S_HOLD, S_INTEG, S_DEINT, S_LOAD} conv_state_t;
endpackage : dmm_ctl_pkg

// [hdl/beeper_tone.sv]
// beeper square wave divider with two selectable tones
`timescale 1ns/1ps
`default_nettype none
module beeper_tone
    import dmm_ctl_pkg::*;
#(
    parameter int CLOCK_HZ = CLK_HZ
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic tone_high,
    input wire logic beep_en,
    // pin
    output logic beep_out
);
    localparam int HALF_HIGH = CLOCK_HZ / (2 * TONE_HIGH_HZ);
    localparam int HALF_LOW = CLOCK_HZ / (2 * TONE_LOW_HZ);
    localparam int DIV_W = $clog2(HALF_LOW + 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic wave;
    } tone_st_t;

    tone_st_t st_ff;
    tone_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // both tones come from the same clock; each half period is rounded down to whole clock cycles
        if (!beep_en) begin
            nxt_st.div = '0;
            nxt_st.wave = 1'b0;
        end else if (st_ff.div >= DIV_W'(tone_high ? HALF_HIGH - 1 : HALF_LOW - 1)) begin // RULE9
            nxt_st.div = '0;
            nxt_st.wave = ~st_ff.wave;
        end else begin
            nxt_st.div = st_ff.div + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign beep_out = st_ff.wave & beep_en; // RULE10
endmodule : beeper_tone
`default_nettype wire

// [hdl/dmm_adc_register_control.sv]
// register file, conversion sequencer and control outputs of the multimeter converter
// What this block does
// RULE1: results are tens-wrapped BCD, single zero code
// RULE2: registers 0 to 4 hold digits, low first
// RULE3: continuity bit latches any threshold crossing
// RULE4: reading status clears the continuity latch
// RULE5: D0 follows low battery, D3 reads one
// RULE6: running bit low while held
// RULE7: hold set stops after the next conversion
// RULE8: hold cleared starts conversion next cycle
// RULE9: tone bit picks 4096 or 2048 Hz
// RULE10: beeper driven only while enabled
// RULE11: standby powers analog down, clock keeps running
// RULE12: range bits drive attenuator switches
// RULE13: range bits act only with divider sense
// RULE14: mains bit picks 655 or 545 cycles
// RULE15: doubling uses second resistor during integration
// RULE16: divide-by-five shortens integration fivefold
// RULE17: ohms bit selects resistance measurement
// RULE18: zero bit shorts inputs for next conversion
// RULE19: filter enable and bypass select filter setup
// RULE20: direct coupling bit picks DC or AC
// RULE21: current input when sense low, current set
// RULE22: control copies to active rank on 21st cycle
// RULE23: in hold the second rank is transparent
`timescale 1ns/1ps
`default_nettype none
module dmm_adc_register_control
    import dmm_ctl_pkg::*;
#(
    parameter int CLOCK_HZ = CLK_HZ
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host bus pins
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DATA_W-1:0] bus_d_in,
    output logic [DATA_W-1:0] bus_d_out,
    output logic bus_d_oe,
    output logic eoc,
    // analog front end
    input wire logic signed [RES_W-1:0] deint_count,
    input wire logic continuity_below,
    input wire logic low_battery,
    output logic integrating,
    output logic analog_power_down,
    output logic [4:0] range_switch,
    output logic direct_400mv_sel,
    output logic current_sel,
    output logic ohms_mode,
    output logic direct_coupling_bit,
    output logic external_ac_bit,
    output logic inputs_shorted,
    output logic mains_rate_bit,
    output logic filter_enable,
    output logic filter_resistor_first_bypass,
    output logic integrator_resistor_first,
    output logic integrator_resistor_second,
    // beeper pin
    output logic beep_out
);
    typedef logic [DIGITS-1:0][DATA_W-1:0] rank_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr_s1;
        logic [ADDR_W-1:0] addr_s2;
        logic [DATA_W-1:0] data_s1;
        logic [DATA_W-1:0] data_s2;
        logic wr_s1;
        logic wr_s2;
        logic wr_s3;
        logic rd_s1;
        logic rd_s2;
        logic rd_s3;
        logic cont_s1;
        logic cont_s2;
        logic bat_s1;
        logic bat_s2;
        rank_t shadow;
        rank_t active;
        conv_state_t state;
        logic [CNT_W-1:0] cnt;
        logic zero_conv;
        logic eoc;
        rank_t result;
        logic cont_latch;
        logic [DATA_W-1:0] rd_data;
        logic rd_oe;
    } ctl_st_t;

    localparam rank_t CTL_RESET = {CTL_GAIN_RESET, CTL_OTHER_RESET, CTL_OTHER_RESET,
                                   CTL_OTHER_RESET, CTL_OTHER_RESET};
    localparam ctl_st_t ST_RESET = '{shadow: CTL_RESET, active: CTL_RESET, state: S_HOLD, default: '0};
    localparam int DEINT_BASE = CONV_CYCLES - LOAD_DELAY;

    ctl_st_t st_ff;
    ctl_st_t nxt_st;

    // wrap negative counts into the upper half so that minus one reads all nines
    function automatic rank_t to_bcd(input logic signed [RES_W-1:0] raw);
        logic [RES_W-1:0] bin;
        logic [RES_W+DIGITS*DATA_W-1:0] sh;
        bin = raw[RES_W-1] ? RESULT_MODULUS + $unsigned(raw) : $unsigned(raw); // RULE1
        sh = {{(DIGITS*DATA_W){1'b0}}, bin};
        for (int i = 0; i < RES_W; i++) begin
            for (int d = 0; d < DIGITS; d++) begin
                if (sh[RES_W+d*DATA_W +: DATA_W] > 4'h4) begin
                    sh[RES_W+d*DATA_W +: DATA_W] = sh[RES_W+d*DATA_W +: DATA_W] + 4'h3;
                end
            end
            sh = sh << 1;
        end
        return sh[RES_W +: DIGITS*DATA_W];
    endfunction : to_bcd

    function automatic logic [CNT_W-1:0] integ_len(input rank_t ctl);
        int len;
        len = ctl[ADDR_CTL_FILT][BIT_MAINS] ? INTEG_MAINS50 : INTEG_MAINS60; // RULE14
        if (ctl[ADDR_CTL_FILT][BIT_DIV5]) begin
            len = len / INTEG_SHRINK; // RULE16
        end
        return CNT_W'(len);
    endfunction : integ_len

    logic wr_done;
    logic rd_done;
    logic status_read;

    assign wr_done = st_ff.wr_s3 & ~st_ff.wr_s2;
    assign rd_done = st_ff.rd_s3 & ~st_ff.rd_s2;
    assign status_read = rd_done & (st_ff.addr_s2 == ADDR_STATUS);

    always_comb begin
        nxt_st = st_ff;
        // pins cross into the clock domain through two flops each
        nxt_st.addr_s1 = bus_addr;
        nxt_st.addr_s2 = st_ff.addr_s1;
        nxt_st.data_s1 = bus_d_in;
        nxt_st.data_s2 = st_ff.data_s1;
        nxt_st.wr_s1 = ~wr_n;
        nxt_st.wr_s2 = st_ff.wr_s1;
        nxt_st.wr_s3 = st_ff.wr_s2;
        nxt_st.rd_s1 = ~rd_n;
        nxt_st.rd_s2 = st_ff.rd_s1;
        nxt_st.rd_s3 = st_ff.rd_s2;
        nxt_st.cont_s1 = continuity_below;
        nxt_st.cont_s2 = st_ff.cont_s1;
        nxt_st.bat_s1 = low_battery;
        nxt_st.bat_s2 = st_ff.bat_s1;

        // the write takes effect when the strobe ends, with the address still held
        if (wr_done && st_ff.addr_s2 < ADDR_W'(DIGITS)) begin
            nxt_st.shadow[st_ff.addr_s2] = st_ff.data_s2;
        end

        // a crossing in the clearing cycle survives the read
        nxt_st.cont_latch = st_ff.cont_s2 | (st_ff.cont_latch & ~status_read); // RULE3 RULE4

        unique case (st_ff.state)
            S_HOLD: begin
                nxt_st.active = nxt_st.shadow; // RULE23
                nxt_st.eoc = 1'b0;
                if (!nxt_st.active[ADDR_CTL_RUN][BIT_HOLD]) begin // RULE8
                    nxt_st.state = S_INTEG;
                    nxt_st.cnt = '0;
                    nxt_st.zero_conv = nxt_st.active[ADDR_CTL_GAIN][BIT_ZERO]; // RULE18
                end
            end

            S_INTEG: begin
                nxt_st.cnt = st_ff.cnt + CNT_W'(1);
                if (st_ff.cnt == integ_len(st_ff.active) - CNT_W'(1)) begin
                    nxt_st.state = S_DEINT;
                end
            end

            S_DEINT: begin
                nxt_st.cnt = st_ff.cnt + CNT_W'(1);
                // the front end count is final in this cycle
                if (st_ff.cnt == CNT_W'(DEINT_BASE - 1)) begin
                    nxt_st.result = to_bcd(deint_count); // RULE1 RULE2
                    nxt_st.eoc = 1'b1;
                    nxt_st.state = S_LOAD;
                    nxt_st.cnt = CNT_W'(1);
                end
            end

            S_LOAD: begin
                nxt_st.cnt = st_ff.cnt + CNT_W'(1);
                if (st_ff.cnt == CNT_W'(LOAD_DELAY)) begin
                    nxt_st.active = nxt_st.shadow; // RULE22
                    nxt_st.eoc = 1'b0;
                    nxt_st.cnt = '0;
                    // a hold written before the load stops here, after the finished conversion
                    if (nxt_st.active[ADDR_CTL_RUN][BIT_HOLD]) begin // RULE7
                        nxt_st.state = S_HOLD;
                    end else begin
                        nxt_st.state = S_INTEG;
                        nxt_st.zero_conv = nxt_st.active[ADDR_CTL_GAIN][BIT_ZERO]; // RULE18
                    end
                end
            end
        endcase

        // read data is registered; status is assembled from live flags
        nxt_st.rd_oe = st_ff.rd_s2;
        if (st_ff.addr_s2 == ADDR_STATUS) begin
            nxt_st.rd_data[ST_ALWAYS1] = 1'b1; // RULE5
            nxt_st.rd_data[ST_CONT] = st_ff.cont_latch; // RULE3
            nxt_st.rd_data[ST_RUNNING] = (st_ff.state != S_HOLD); // RULE6
            nxt_st.rd_data[ST_LOWBAT] = st_ff.bat_s2; // RULE5
        end else if (st_ff.addr_s2 < ADDR_W'(DIGITS)) begin
            nxt_st.rd_data = st_ff.result[st_ff.addr_s2]; // RULE2
        end else begin
            nxt_st.rd_data = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs from the active rank
    logic [DATA_W-1:0] c_run;
    logic [DATA_W-1:0] c_filt;
    logic [DATA_W-1:0] c_range;
    logic [DATA_W-1:0] c_input;
    logic [DATA_W-1:0] c_gain;
    logic converting;

    assign c_run = st_ff.active[ADDR_CTL_RUN];
    assign c_filt = st_ff.active[ADDR_CTL_FILT];
    assign c_range = st_ff.active[ADDR_CTL_RANGE];
    assign c_input = st_ff.active[ADDR_CTL_INPUT];
    assign c_gain = st_ff.active[ADDR_CTL_GAIN];
    assign converting = (st_ff.state == S_INTEG) || (st_ff.state == S_DEINT);

    assign bus_d_out = st_ff.rd_data;
    assign bus_d_oe = st_ff.rd_oe;
    assign eoc = st_ff.eoc;
    assign integrating = (st_ff.state == S_INTEG);
    assign analog_power_down = c_run[BIT_STANDBY]; // RULE11
    assign range_switch = {c_range, c_filt[BIT_RANGE0]} & {5{c_input[BIT_DIV_SENSE]}}; // RULE12 RULE13
    assign direct_400mv_sel = ~c_input[BIT_DIV_SENSE] & ~c_gain[BIT_CURRENT]; // RULE21
    assign current_sel = ~c_input[BIT_DIV_SENSE] & c_gain[BIT_CURRENT]; // RULE21
    assign ohms_mode = c_input[BIT_OHMS]; // RULE17
    assign direct_coupling_bit = c_input[BIT_DC]; // RULE20
    assign external_ac_bit = c_input[BIT_EXTERNAL_AC_BIT]; // RULE20
    assign inputs_shorted = st_ff.zero_conv & converting; // RULE18
    assign mains_rate_bit = c_filt[BIT_MAINS];
    // the undefined 00 setting is passed through as written; avoiding it is up to software
    assign filter_enable = c_gain[BIT_FILT_ON]; // RULE19
    assign filter_resistor_first_bypass = c_filt[BIT_FILT_SHORT]; // RULE19
    assign integrator_resistor_first = ~(c_gain[BIT_DOUBLE] & integrating); // RULE15
    assign integrator_resistor_second = 1'b1;

    beeper_tone #(
        .CLOCK_HZ(CLOCK_HZ)
    ) u_beeper (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tone_high(c_run[BIT_TONE]), // RULE9
        .beep_en(c_run[BIT_BEEP]), // RULE10
        .beep_out(beep_out)
    );

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // length of the integration phase so far, for the period check
    logic [CNT_W-1:0] integ_run_h;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            integ_run_h <= '0;
        end else begin
            integ_run_h <= integrating ? integ_run_h + CNT_W'(1) : '0;
        end
    end

    a_status_fixed: assert property ((st_ff.addr_s2 == ADDR_STATUS) |=> bus_d_out[ST_ALWAYS1]) // RULE5
        else $error("status top bit not one");
    a_cont_sets: assert property (st_ff.cont_s2 |=> st_ff.cont_latch) // RULE3
        else $error("continuity latch missed a crossing");
    a_cont_clears: assert property (status_read && !st_ff.cont_s2 |=> !st_ff.cont_latch) // RULE4
        else $error("status read did not clear continuity");

    a_hold_flag: assert property ((st_ff.addr_s2 == ADDR_STATUS && st_ff.state == S_HOLD) // RULE6
                                  |=> !bus_d_out[ST_RUNNING])
        else $error("running flag high while held");
    a_hold_restart: assert property (st_ff.state == S_HOLD && !nxt_st.active[ADDR_CTL_RUN][BIT_HOLD] // RULE8
                                     |=> integrating)
        else $error("no restart after hold cleared");

    a_beep_quiet: assert property (!c_run[BIT_BEEP] |-> !beep_out) // RULE10
        else $error("beeper driven while off");
    a_range_gate: assert property (!c_input[BIT_DIV_SENSE] |-> range_switch == '0) // RULE13
        else $error("range switch without divider sense");
    a_integ_length: assert property ($fell(integrating) |-> integ_run_h == integ_len(st_ff.active)) // RULE14 RULE16
        else $error("integration period wrong");
    a_double_res: assert property (integrating && c_gain[BIT_DOUBLE] |-> !integrator_resistor_first) // RULE15
        else $error("first resistor used while doubling");

    a_load_21: assert property ($rose(eoc) |-> $stable(st_ff.active) [*8] ##13 (st_ff.state == S_LOAD) // RULE22
                               ##1 (st_ff.state != S_LOAD))
        else $error("active rank load off cycle");
    a_hold_stop: assert property ($fell(eoc) && st_ff.active[ADDR_CTL_RUN][BIT_HOLD] |-> st_ff.state == S_HOLD) // RULE7
        else $error("conversion continued under hold");

    // the active rank only moves between conversions
    a_rank_frozen: assert property (converting |=> $stable(st_ff.active)) // RULE22
        else $error("rank moved mid conversion");
    a_eoc_in_load: assert property (eoc |-> st_ff.state == S_LOAD) // RULE22
        else $error("eoc outside load");

    a_hold_clear: assert property (st_ff.state == S_HOLD |=> st_ff.active == st_ff.shadow) // RULE23
        else $error("hold rank not transparent");

    a_run_flag: assert property ((st_ff.addr_s2 == ADDR_STATUS && st_ff.state != S_HOLD) // RULE6
                                 |=> bus_d_out[ST_RUNNING])
        else $error("running flag low while converting");
    a_bat_flag: assert property (st_ff.addr_s2 == ADDR_STATUS // RULE5
                                 |=> bus_d_out[ST_LOWBAT] == $past(st_ff.bat_s2))
        else $error("low battery flag wrong");

    a_result_held: assert property (!$rose(eoc) |-> $stable(st_ff.result)) // RULE2
        else $error("result changed between conversions");
    a_source_one: assert property (!(direct_400mv_sel && current_sel)) // RULE21
        else $error("two input sources selected");

    c_conversion: cover property ($rose(eoc));
    c_status_clear: cover property (status_read && st_ff.cont_latch);
    c_hold_resume: cover property (st_ff.state == S_HOLD ##1 integrating);
    c_zero_reading: cover property (inputs_shorted && integrating);
    c_write_in_conv: cover property (wr_done && converting);
endmodule : dmm_adc_register_control
`default_nettype wire

// [testbench/dmm_host_model.sv]
// host processor model driving the register bus pins of the converter control
`timescale 1ns/1ps
`default_nettype none
module dmm_host_model
    import dmm_ctl_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // bus pins
    output logic [ADDR_W-1:0] bus_addr,
    output logic rd_n,
    output logic wr_n,
    output logic [DATA_W-1:0] bus_d_in
);
    // extra strobe cycles, so the host can also be slow
    int stretch = 0;

    initial begin
        bus_addr = 3'h0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        bus_d_in = 4'h0;
    end

    // pins are synced inside, so every level is held three cycles around a strobe
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_d_in = d;
        repeat (3) @(negedge clk_sys);
        wr_n = 1'b0;
        repeat (3 + stretch) @(negedge clk_sys);
        wr_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        // released data no longer shows the written value
        bus_d_in = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [ADDR_W-1:0] a);
        @(negedge clk_sys);
        bus_addr = a;
        repeat (4) @(negedge clk_sys);
        rd_n = 1'b0;
        repeat (6 + stretch) @(negedge clk_sys);
        rd_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : read_reg
endmodule : dmm_host_model
`default_nettype wire

// [testbench/dmm_adc_register_control_tb.sv]
// self-checking testbench of the multimeter converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", name, exp, got); end end
module dmm_adc_register_control_tb;
    import dmm_ctl_pkg::*;
    // small clock figure keeps beeper half periods at 2 and 4 cycles
    localparam int TB_CLOCK_HZ = 16384;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    wire logic [ADDR_W-1:0] bus_addr;
    wire logic rd_n, wr_n;
    wire logic [DATA_W-1:0] bus_d_in;
    logic [DATA_W-1:0] bus_d_out, exp_v;
    logic bus_d_oe, eoc, integrating, analog_power_down, direct_400mv_sel, current_sel, ohms_mode;
    logic direct_coupling_bit, external_ac_bit, inputs_shorted, mains_rate_bit, filter_enable;
    logic filter_resistor_first_bypass, integrator_resistor_first, integrator_resistor_second, beep_out;
    logic [4:0] range_switch;
    logic signed [RES_W-1:0] deint_count = '0;
    logic continuity_below = 1'b0;
    logic low_battery = 1'b0;
    logic rd_last = 1'b1;
    logic [DATA_W-1:0] exp_q[$];
    int miscompares = 0, num_checks = 0, seed = 32'h0499;
    int run_len = 0, sh_cnt = 0, r1_cnt = 0, integ_len = 0, integ_sh = 0, integ_r1 = 0;
    int eoc_run = 0, eoc_len = 0, n_starts = 0;

    always #12.5 clk_sys = ~clk_sys;

    dmm_host_model host (.clk_sys(clk_sys), .bus_addr(bus_addr), .rd_n(rd_n), .wr_n(wr_n), .bus_d_in(bus_d_in));

    dmm_adc_register_control #(.CLOCK_HZ(TB_CLOCK_HZ)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .rd_n(rd_n), .wr_n(wr_n),
        .bus_d_in(bus_d_in), .bus_d_out(bus_d_out), .bus_d_oe(bus_d_oe), .eoc(eoc),
        .deint_count(deint_count), .continuity_below(continuity_below), .low_battery(low_battery),
        .integrating(integrating), .analog_power_down(analog_power_down), .range_switch(range_switch),
        .direct_400mv_sel(direct_400mv_sel), .current_sel(current_sel), .ohms_mode(ohms_mode),
        .direct_coupling_bit(direct_coupling_bit), .external_ac_bit(external_ac_bit),
        .inputs_shorted(inputs_shorted), .mains_rate_bit(mains_rate_bit), .filter_enable(filter_enable),
        .filter_resistor_first_bypass(filter_resistor_first_bypass),
        .integrator_resistor_first(integrator_resistor_first),
        .integrator_resistor_second(integrator_resistor_second), .beep_out(beep_out));

    // read data is compared at the first edge after the strobe ends, while still driven
    always @(posedge clk_sys) begin
        if (rd_n === 1'b1 && rd_last === 1'b0 && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, bus_d_out)
            `CHK("read enable", 1'b1, bus_d_oe)
        end
        rd_last <= rd_n;
        if (integrating === 1'b1) begin
            if (run_len == 0) n_starts++;
            run_len++;
            sh_cnt += int'(inputs_shorted === 1'b1);
            r1_cnt += int'(integrator_resistor_first === 1'b1);
        end else if (run_len != 0) begin
            integ_len = run_len;
            integ_sh = sh_cnt;
            integ_r1 = r1_cnt;
            run_len = 0;
            sh_cnt = 0;
            r1_cnt = 0;
        end
        if (eoc === 1'b1) eoc_run++;
        else if (eoc_run != 0) begin
            eoc_len = eoc_run;
            eoc_run = 0;
        end
    end

    function automatic logic [3:0] digit_of(input int v, input int i);
        int c;
        c = (v < 0) ? 100000 + v : v;
        repeat (i) c = c / 10;
        return 4'(c % 10);
    endfunction : digit_of

    task automatic expect_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        exp_q.push_back(d);
        host.read_reg(a);
    endtask : expect_read

    task automatic wait_conv();
        int i;
        for (i = 0; i < 2000 && eoc !== 1'b1; i++) @(negedge clk_sys);
        `CHK("eoc rise", 1'b1, eoc)
        for (i = 0; i < 40 && eoc !== 1'b0; i++) @(negedge clk_sys);
        `CHK("eoc fall", 1'b0, eoc)
        // one more edge lets the monitor close the eoc run
        @(negedge clk_sys);
    endtask : wait_conv

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    // about 30k cycles of tests, so over three times that means a hang
    initial begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end

    initial begin : main
        int i, k, v, nk, tg, exp_len;
        int vals[8];
        logic prev;
        logic [3:0] c0, c1, c2, c3, c4;
        low_battery = 1'($random(seed));
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK("ctl reset", 5'b10000, {filter_enable, filter_resistor_first_bypass, analog_power_down,
            mains_rate_bit, ohms_mode})
        expect_read(ADDR_STATUS, {1'b1, 1'b0, 1'b1, low_battery});
        $display("test reset done");
        vals = '{0, 1, -1, -100, 40000, -40000, 0, 0};
        vals[6] = $random(seed) % 40001;
        vals[7] = $random(seed) % 40001;
        for (k = 0; k < 8; k++) begin
            deint_count = 17'(vals[k]);
            wait_conv();
            for (i = 0; i < DIGITS; i++) expect_read(3'(i), digit_of(vals[k], i));
        end
        expect_read(3'h6, 4'h0);
        $display("test results done");
        continuity_below = 1'b1;
        repeat (3) @(negedge clk_sys);
        continuity_below = 1'b0;
        low_battery = ~low_battery;
        expect_read(ADDR_STATUS, {1'b1, 1'b1, 1'b1, low_battery});
        expect_read(ADDR_STATUS, {1'b1, 1'b0, 1'b1, low_battery});
        $display("test status done");
        wait_conv();
        host.write_reg(ADDR_CTL_RUN, 4'h8);
        wait_conv();
        v = n_starts;
        repeat (1800) @(negedge clk_sys);
        `CHK("held starts", v, n_starts)
        expect_read(ADDR_STATUS, {1'b1, 1'b0, 1'b0, low_battery});
        for (k = 0; k < 6; k++) begin
            host.stretch = (k % 2) * 3;
            c0 = {1'b1, 2'(k), 1'($random(seed))};
            c1 = 4'($random(seed));
            c2 = 4'($random(seed));
            c3 = 4'($random(seed));
            c4 = 4'($random(seed));
            if (!c3[BIT_DC]) c3[BIT_EXTERNAL_AC_BIT] = 1'b1;
            if (c3[BIT_OHMS]) c3[BIT_DIV_SENSE] = 1'b0;
            if (c3[BIT_OHMS]) c3[BIT_DC] = 1'b1;
            if (!c1[BIT_FILT_SHORT]) c4[BIT_FILT_ON] = 1'b1;
            host.write_reg(ADDR_CTL_RUN, c0);
            host.write_reg(ADDR_CTL_FILT, c1);
            host.write_reg(ADDR_CTL_RANGE, c2);
            host.write_reg(ADDR_CTL_INPUT, c3);
            host.write_reg(ADDR_CTL_GAIN, c4);
            `CHK("range", c3[BIT_DIV_SENSE] ? {c2, c1[BIT_RANGE0]} : 5'h00, range_switch)
            `CHK("source", {~c3[BIT_DIV_SENSE] & ~c4[BIT_CURRENT], ~c3[BIT_DIV_SENSE] & c4[BIT_CURRENT]},
                {direct_400mv_sel, current_sel})
            `CHK("mode", {c3[BIT_OHMS], c3[BIT_DC], c3[BIT_EXTERNAL_AC_BIT], c1[BIT_MAINS]},
                {ohms_mode, direct_coupling_bit, external_ac_bit, mains_rate_bit})
            `CHK("filter", {c4[BIT_FILT_ON], c1[BIT_FILT_SHORT]},
                {filter_enable, filter_resistor_first_bypass})
            `CHK("standby", c0[BIT_STANDBY], analog_power_down)
            tg = 0;
            prev = beep_out;
            repeat (64) begin
                @(negedge clk_sys);
                tg += int'(beep_out !== prev);
                prev = beep_out;
            end
            `CHK("beep toggles", c0[BIT_BEEP] ? (c0[BIT_TONE] ? 32 : 16) : 0, tg)
            `CHK("beep idle", 1'b0, c0[BIT_BEEP] ? 1'b0 : beep_out)
        end
        host.stretch = 0;
        $display("test hold decode done");
        host.write_reg(ADDR_CTL_FILT, 4'h4);
        host.write_reg(ADDR_CTL_GAIN, 4'h1);
        host.write_reg(ADDR_CTL_INPUT, 4'h8);
        for (k = 0; k < 4; k++) begin
            integ_len = 0;
            host.write_reg(ADDR_CTL_RUN, 4'h0);
            `CHK("start", 1'b1, integrating)
            for (i = 0; i < 800 && integ_len == 0; i++) @(negedge clk_sys);
            exp_len = (k[0] ? INTEG_MAINS50 : INTEG_MAINS60) / (k[1] ? INTEG_SHRINK : 1);
            `CHK("integ len", exp_len, integ_len)
            `CHK("shorted", k[1] ? exp_len : 0, integ_sh)
            `CHK("resistor", (k[0] ^ k[1]) ? 0 : exp_len, integ_r1)
            `CHK("resistor two", 1'b1, integrator_resistor_second)
            nk = (k + 1) % 4;
            host.write_reg(ADDR_CTL_FILT, {2'b01, 1'(nk >> 1), 1'(nk)});
            host.write_reg(ADDR_CTL_GAIN, {1'b0, 1'(nk) ^ 1'(nk >> 1), 1'(nk >> 1), 1'b1});
            host.write_reg(ADDR_CTL_RUN, 4'h8);
            `CHK("rank held", 1'(k), mains_rate_bit)
            wait_conv();
            `CHK("load len", LOAD_DELAY, eoc_len)
            `CHK("rank loaded", 1'(nk), mains_rate_bit)
        end
        $display("test integration done");
        finish_test();
    end
endmodule : dmm_adc_register_control_tb
`default_nettype wire
